// ==== hw/vps_modulator.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// luminance and chroma modulator
// ****************************************
module vps_modulator (
  input  wire logic [7:0] colour_byte,
  input  wire logic [3:0] phase,
  input  wire logic       carrier_on,
  input  wire logic       carrier_level,
  output logic      [3:0] baseband,
  output logic      [3:0] broadcast
);

  logic [2:0] lum;
  logic [3:0] hue_sum;

  assign lum     = colour_byte[vps_pkg::LUM_LSB +: vps_pkg::LUM_W];
  assign hue_sum = phase + colour_byte[vps_pkg::HUE_LSB +: vps_pkg::PHASE_W];

  // swing by one around luminance; clamp at zero, no wrap to full scale
  always_comb begin
    if (!colour_byte[vps_pkg::MOD_BIT]) begin
      baseband = {1'b0, lum};
    end else if (hue_sum[vps_pkg::SWING_BIT]) begin
      baseband = {1'b0, lum} + 4'h1;
    end else if (lum == 3'h0) begin
      baseband = 4'h0;
    end else begin
      baseband = {1'b0, lum} - 4'h1;
    end
  end

  // carrier gates the baseband onto the broadcast nibble
  always_comb begin
    if (carrier_on && carrier_level) begin
      broadcast = baseband;
    end else begin
      broadcast = 4'h0;
    end
  end

endmodule // vps_modulator
`default_nettype wire

// ==== hw/vps_pin_steer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pin group steering and mask
// ****************************************
module vps_pin_steer #(
  parameter int GROUPS = 4
) (
  input  wire logic        enable,
  input  wire logic [2:0]  group_sel,
  input  wire logic [7:0]  mask,
  input  wire logic [7:0]  byte_in,
  output logic      [31:0] pins,
  output logic      [31:0] oe
);

  generate
    if (GROUPS < 1 || GROUPS * 8 > 32) begin : g_bad_groups
      $error("pin group count does not fit the pin word");
    end
  endgenerate

  // reserved group codes drive nothing
  always_comb begin
    pins = 32'h0000_0000;
    oe   = 32'h0000_0000;
    for (int g = 0; g < GROUPS; g++) begin
      if (enable && group_sel == 3'(g)) begin
        pins[g*8 +: 8] = byte_in & mask;
        oe[g*8 +: 8]   = mask;
      end
    end
  end

endmodule // vps_pin_steer
`default_nettype wire

// ==== hw/vps_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// video pixel serializer
// ****************************************
module vps_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        pixel_synth_clock,
  input  wire logic        broadcast_synth_clock,
  input  wire logic        broadcast_synth_run,
  input  wire logic [1:0]  video_output_kind,
  input  wire logic        color_depth_select,
  input  wire logic [2:0]  output_pin_group,
  input  wire logic [7:0]  output_pin_mask,
  input  wire logic [7:0]  pixel_period_count,
  input  wire logic [11:0] frame_period_count,
  input  wire logic [31:0] colour_operand,
  input  wire logic [31:0] pixel_operand,
  input  wire logic        handoff_waiting,
  output logic             handoff_release,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [8:0] pix_full(input logic [7:0] c);
    pix_full = (c == 8'h00) ? vps_pkg::PIX_ZERO_FULL : {1'b0, c};
  endfunction

  function automatic logic [12:0] frm_full(input logic [11:0] c);
    frm_full = (c == 12'h000) ? vps_pkg::FRM_ZERO_FULL : {1'b0, c};
  endfunction

  // colour entry chosen by the lowest pixel of the word
  function automatic logic [7:0] pick_colour(input logic [31:0] col,
                                             input logic [31:0] pix,
                                             input logic        depth);
    logic [1:0] idx;
    idx = (depth == vps_pkg::DEPTH_FOUR) ? pix[1:0] : {1'b0, pix[0]};
    pick_colour = col[idx*8 +: 8];
  endfunction

  // ****************************************
  // state
  // ****************************************
  vps_pkg::vps_state_t state_reg;
  vps_pkg::vps_state_t state_next;

  logic        tick;
  logic        boundary;
  logic [7:0]  cur_byte;
  logic [3:0]  baseband;
  logic [3:0]  broadcast;
  logic        carrier_on;
  logic [7:0]  out_byte;
  logic        out_enable;
  logic [31:0] steer_pins;
  logic [31:0] steer_oe;

  // synth clock edge seen on the synchronised copy only
  assign tick     = state_reg.pclk_s2 & ~state_reg.pclk_s3;
  // counter at zero after reset makes the first edge a boundary
  assign boundary = tick && (state_reg.frm_cnt <= vps_pkg::FRM_LAST);

  assign cur_byte = pick_colour(state_reg.colours, state_reg.pixels,
                                color_depth_select);

  // broadcast only where the kind puts it and the mask lets it out
  always_comb begin
    case (video_output_kind)
      vps_pkg::KIND_COMP1: begin
        carrier_on = broadcast_synth_run && (output_pin_mask[7:4] != 4'h0);
      end
      vps_pkg::KIND_COMP2: begin
        carrier_on = broadcast_synth_run && (output_pin_mask[3:0] != 4'h0);
      end
      default: begin
        carrier_on = 1'b0;
      end
    endcase
  end

  // ****************************************
  // modulator and pin steering
  // ****************************************
  vps_modulator u_mod (
    .colour_byte   (cur_byte),
    .phase         (state_reg.phase),
    .carrier_on    (carrier_on),
    .carrier_level (state_reg.bclk_s2),
    .baseband      (baseband),
    .broadcast     (broadcast)
  );

  // byte layout per output kind
  always_comb begin
    out_enable = 1'b1;
    case (video_output_kind)
      vps_pkg::KIND_VGA: begin
        out_byte = cur_byte;
      end
      vps_pkg::KIND_COMP1: begin
        out_byte = {broadcast, baseband};
      end
      vps_pkg::KIND_COMP2: begin
        out_byte = {baseband, broadcast};
      end
      default: begin
        out_byte   = 8'h00;
        out_enable = 1'b0;
      end
    endcase
  end

  vps_pin_steer #(
    .GROUPS (4)
  ) u_steer (
    .enable    (out_enable),
    .group_sel (output_pin_group),
    .mask      (output_pin_mask),
    .byte_in   (out_byte),
    .pins      (steer_pins),
    .oe        (steer_oe)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    // two-stage synchronisers, stage one read only by stage two
    state_next.pclk_s1 = pixel_synth_clock;
    state_next.pclk_s2 = state_reg.pclk_s1;
    state_next.pclk_s3 = state_reg.pclk_s2;
    state_next.bclk_s1 = broadcast_synth_clock;
    state_next.bclk_s2 = state_reg.bclk_s1;
    // release only meaningful while the core sits in its wait
    state_next.release_p = boundary & handoff_waiting;
    if (tick) begin
      state_next.phase = state_reg.phase + 4'h1;
    end
    if (boundary) begin
      // buses are taken as they stand, waiting or not
      state_next.colours = colour_operand;
      state_next.pixels  = pixel_operand;
      state_next.pix_cnt = pix_full(pixel_period_count);
      state_next.frm_cnt = frm_full(frame_period_count);
    end else if (tick) begin
      state_next.frm_cnt = state_reg.frm_cnt - 13'h0001;
      if (state_reg.pix_cnt <= vps_pkg::PIX_LAST) begin
        state_next.pix_cnt = pix_full(pixel_period_count);
        // shifting in copies of the top bits makes them repeat
        if (color_depth_select == vps_pkg::DEPTH_FOUR) begin
          state_next.pixels = {state_reg.pixels[31:30],
                               state_reg.pixels[31:2]};
        end else begin
          state_next.pixels = {state_reg.pixels[31],
                               state_reg.pixels[31:1]};
        end
      end else begin
        state_next.pix_cnt = state_reg.pix_cnt - 9'h001;
      end
    end
    state_next.pin_out = steer_pins;
    state_next.pin_oe  = steer_oe;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= vps_pkg::STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign handoff_release = state_reg.release_p;
  assign pin_out         = state_reg.pin_out;
  assign pin_oe          = state_reg.pin_oe;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_boundary_load: assert property (
    boundary |=> state_reg.colours == $past(colour_operand)
              && state_reg.pixels == $past(pixel_operand))
    else $error("operands not loaded at frame boundary");

  a_counter_restart: assert property (
    boundary |=> state_reg.frm_cnt == frm_full($past(frame_period_count))
              && state_reg.pix_cnt == pix_full($past(pixel_period_count)))
    else $error("period counters not restarted at boundary");

  a_release_pulse: assert property (
    (boundary && handoff_waiting) |=> handoff_release ##1 !handoff_release)
    else $error("handoff release not a single pulse after boundary");

  a_off_quiet: assert property (
    (video_output_kind == vps_pkg::KIND_OFF) |=> pin_oe == 32'h0000_0000)
    else $error("pins driven while output is off");

  a_vga_direct: assert property (
    (video_output_kind == vps_pkg::KIND_VGA && output_pin_group == 3'h0
     && output_pin_mask == 8'hFF) |=> pin_out[7:0] == $past(cur_byte))
    else $error("vga byte not driven unmodified");

  a_mask_gate: assert property (
    ##1 (pin_out & ~pin_oe) == 32'h0000_0000)
    else $error("pin value outside the mask");

  a_four_shift: assert property (
    (tick && !boundary && state_reg.pix_cnt == 9'h001
     && color_depth_select == vps_pkg::DEPTH_FOUR)
    |=> state_reg.pixels == {$past(state_reg.pixels[31:30]),
                             $past(state_reg.pixels[31:2])})
    else $error("four-colour shift wrong");

  a_two_pick: assert property (
    (color_depth_select == vps_pkg::DEPTH_TWO)
    |-> cur_byte == (state_reg.pixels[0] ? state_reg.colours[15:8]
                                         : state_reg.colours[7:0]))
    else $error("two-colour entry selection wrong");

  a_mod_off: assert property (
    !cur_byte[3] |-> baseband == {1'b0, cur_byte[2:0]})
    else $error("luminance altered with modulation off");

  a_mod_swing: assert property (
    (cur_byte[3] && cur_byte[2:0] != 3'h0)
    |-> (baseband == {1'b0, cur_byte[2:0]} + 4'h1
         || baseband == {1'b0, cur_byte[2:0]} - 4'h1))
    else $error("modulated luminance not swung by one");

  a_carrier_gate: assert property (
    !broadcast_synth_run |-> broadcast == 4'h0)
    else $error("carrier present without broadcast synth");

  a_carrier_level: assert property (
    !state_reg.bclk_s2 |-> broadcast == 4'h0)
    else $error("carrier present while its clock is low");

  a_two_shift: assert property (
    (tick && !boundary && state_reg.pix_cnt == 9'h001
     && color_depth_select == vps_pkg::DEPTH_TWO)
    |=> state_reg.pixels == {$past(state_reg.pixels[31]),
                             $past(state_reg.pixels[31:1])})
    else $error("two-colour shift wrong");

  // pixels only move at the end of a pixel period or on a load
  a_pixel_hold: assert property (
    (!boundary && !(tick && state_reg.pix_cnt <= vps_pkg::PIX_LAST))
    |=> state_reg.pixels == $past(state_reg.pixels))
    else $error("pixel word moved inside a pixel period");

  a_frame_count: assert property (
    (tick && !boundary) |=> state_reg.frm_cnt == $past(state_reg.frm_cnt) - 13'h0001)
    else $error("frame counter did not step once per tick");

  a_four_pick: assert property (
    (color_depth_select == vps_pkg::DEPTH_FOUR)
    |-> cur_byte == (state_reg.pixels[1]
                     ? (state_reg.pixels[0] ? state_reg.colours[31:24]
                                            : state_reg.colours[23:16])
                     : (state_reg.pixels[0] ? state_reg.colours[15:8]
                                            : state_reg.colours[7:0])))
    else $error("four-colour entry selection wrong");

  c_handoff_waiting: cover property (boundary && handoff_waiting);
  c_handoff_missed: cover property (boundary && !handoff_waiting);
  c_composite_mod: cover property (
    video_output_kind == vps_pkg::KIND_COMP1 && cur_byte[3] && carrier_on);
  c_two_colour_repeat: cover property (
    color_depth_select == vps_pkg::DEPTH_TWO && tick && !boundary
    && state_reg.pix_cnt == 9'h001);

endmodule // vps_top
`default_nettype wire

// ==== inc/vps_pkg.sv ====
`default_nettype none
package vps_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int PIX_CNT_W  = 8;
  localparam int FRM_CNT_W  = 12;
  localparam int PIN_W      = 32;
  localparam int GROUP_W    = 3;
  localparam int BYTE_W     = 8;
  localparam int PHASE_W    = 4;

  // ****************************************
  // period counts, zero meaning full range
  // ****************************************
  localparam logic [8:0]  PIX_ZERO_FULL = 9'h100;
  localparam logic [12:0] FRM_ZERO_FULL = 13'h1000;
  localparam logic [8:0]  PIX_LAST      = 9'h001;
  localparam logic [12:0] FRM_LAST      = 13'h0001;

  // ****************************************
  // output kinds and colour depth
  // ****************************************
  localparam logic [1:0] KIND_OFF   = 2'h0;
  localparam logic [1:0] KIND_VGA   = 2'h1;
  localparam logic [1:0] KIND_COMP1 = 2'h2;
  localparam logic [1:0] KIND_COMP2 = 2'h3;
  localparam logic       DEPTH_TWO  = 1'h0;
  localparam logic       DEPTH_FOUR = 1'h1;

  // ****************************************
  // colour entry fields
  // ****************************************
  localparam int LUM_LSB   = 0;
  localparam int LUM_W     = 3;
  localparam int MOD_BIT   = 3;
  localparam int HUE_LSB   = 4;
  localparam int SWING_BIT = 3;

  // ****************************************
  // whole generator state
  // ****************************************
  typedef struct packed {
    logic              pclk_s1;
    logic              pclk_s2;
    logic              pclk_s3;
    logic              bclk_s1;
    logic              bclk_s2;
    logic [8:0]        pix_cnt;
    logic [12:0]       frm_cnt;
    logic [3:0]        phase;
    logic [31:0]       colours;
    logic [31:0]       pixels;
    logic              release_p;
    logic [31:0]       pin_out;
    logic [31:0]       pin_oe;
  } vps_state_t;

  localparam vps_state_t STATE_RESET = '0;

endpackage
`default_nettype wire

// ==== verif/vps_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// core side of the handoff wait
// ****
module vps_core_model (
  input  wire logic        sys_clk,
  input  wire logic        handoff_release,
  output logic             handoff_waiting,
  output logic      [31:0] colour_operand,
  output logic      [31:0] pixel_operand
);
  initial begin
    handoff_waiting = 1'b0;
    colour_operand = 32'h0;
    pixel_operand = 32'h0;
  end

  // stall with both words until released, then let the buses wander
  task automatic hand(input logic [31:0] col, input logic [31:0] pix, input int lag,
                      output bit ok);
    ok = 1'b0;
    repeat (lag + 1) @(negedge sys_clk);
    handoff_waiting = 1'b1;
    colour_operand = col;
    pixel_operand = pix;
    for (int i = 0; i < 40000 && !ok; i++) begin
      @(posedge sys_clk);
      if (handoff_release === 1'b1) ok = 1'b1;
    end
    @(negedge sys_clk);
    handoff_waiting = 1'b0;
    // inverse, so a late capture cannot pass by chance
    colour_operand = ~col;
    pixel_operand = ~pix;
  endtask
endmodule // vps_core_model
`default_nettype wire

// ==== verif/vps_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module vps_top_tb_top;
  typedef struct {
    logic [1:0]  kind;
    logic        depth;
    logic [2:0]  grp;
    logic [7:0]  mask;
    logic [7:0]  pp;
    logic [11:0] fp;
    logic        run;
  } vps_cfg_t;
  typedef struct {
    logic [31:0] out;
    logic [31:0] alt;
    logic [31:0] oe;
  } vps_exp_t;

  logic        sys_clk, rst_n, pixel_synth_clock, broadcast_synth_clock;
  logic        broadcast_synth_run, color_depth_select, handoff_waiting, handoff_release;
  logic [1:0]  video_output_kind;
  logic [2:0]  output_pin_group;
  logic [7:0]  output_pin_mask, pixel_period_count;
  logic [11:0] frame_period_count;
  logic [31:0] colour_operand, pixel_operand, pin_out, pin_oe;
  int          errors, cmp_count;
  vps_exp_t    exp_q[$];
  int          len_q[$];
  vps_cfg_t    tab[10];

  vps_top i_vps_top (.sys_clk(sys_clk), .rst_n(rst_n), .pixel_synth_clock(pixel_synth_clock),
    .broadcast_synth_clock(broadcast_synth_clock), .broadcast_synth_run(broadcast_synth_run),
    .video_output_kind(video_output_kind), .color_depth_select(color_depth_select),
    .output_pin_group(output_pin_group), .output_pin_mask(output_pin_mask),
    .pixel_period_count(pixel_period_count), .frame_period_count(frame_period_count),
    .colour_operand(colour_operand), .pixel_operand(pixel_operand),
    .handoff_waiting(handoff_waiting), .handoff_release(handoff_release),
    .pin_out(pin_out), .pin_oe(pin_oe));
  vps_core_model i_vps_core_model (.sys_clk(sys_clk), .handoff_release(handoff_release),
    .handoff_waiting(handoff_waiting), .colour_operand(colour_operand),
    .pixel_operand(pixel_operand));

  // system clock, and a synth clock of eight system cycles at an odd phase
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    pixel_synth_clock = 1'b0;
    #7;
    forever #80 pixel_synth_clock = ~pixel_synth_clock;
  end

  // ****
  // expectations
  // ****
  function automatic vps_exp_t exp_pixel(vps_cfg_t c, logic [31:0] col, logic [31:0] pix, int k);
    vps_exp_t e;
    logic [1:0] idx;
    logic [7:0] b, hi, lo;
    logic [3:0] up, dn;
    logic car;
    // past the last pixel the top bits repeat
    idx = c.depth ? ((k < 16) ? pix[2*k +: 2] : pix[31:30])
                  : {1'b0, (k < 32) ? pix[k] : pix[31]};
    b = col[8*idx +: 8];
    up = {1'b0, b[2:0]} + {3'h0, b[3]};
    dn = (b[3] && b[2:0] != 3'h0) ? {1'b0, b[2:0]} - 4'h1 : {1'b0, b[2:0]};
    car = c.run && ((c.kind == vps_pkg::KIND_COMP1 && c.mask[7:4] != 4'h0) ||
                    (c.kind == vps_pkg::KIND_COMP2 && c.mask[3:0] != 4'h0));
    hi = b;
    lo = b;
    if (c.kind == vps_pkg::KIND_COMP1) begin
      hi = {car ? up : 4'h0, up};
      lo = {car ? dn : 4'h0, dn};
    end
    if (c.kind == vps_pkg::KIND_COMP2) begin
      hi = {up, car ? up : 4'h0};
      lo = {dn, car ? dn : 4'h0};
    end
    e.oe = (c.kind == vps_pkg::KIND_OFF || c.grp > 3'h3) ? 32'h0 : {24'h0, c.mask} << (8 * c.grp);
    e.out = ({24'h0, hi} << (8 * c.grp)) & e.oe;
    e.alt = ({24'h0, lo} << (8 * c.grp)) & e.oe;
    return e;
  endfunction

  task automatic compare_pins(input logic [31:0] po, input logic [31:0] oe, input vps_exp_t e);
    cmp_count++;
    if (oe !== e.oe || (po !== e.out && po !== e.alt)) begin
      errors++;
      $display("mismatch t=%0t got %h %h exp %h %h", $time, po, oe, e.out, e.oe);
    end
  endtask

  task automatic compare_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one setting, two frames back to back, then wait out the second frame
  task automatic run_cfg(vps_cfg_t c);
    int n, pe, fe;
    logic [31:0] col, pix;
    bit ok;
    @(negedge sys_clk);
    video_output_kind = c.kind;
    color_depth_select = c.depth;
    output_pin_group = c.grp;
    output_pin_mask = c.mask;
    pixel_period_count = c.pp;
    frame_period_count = c.fp;
    broadcast_synth_run = c.run;
    pe = (c.pp == 8'h00) ? 256 : int'(c.pp);
    fe = (c.fp == 12'h000) ? 4096 : int'(c.fp);
    n = fe / pe;
    for (int f = 0; f < 2; f++) begin
      col = $urandom();
      pix = $urandom();
      len_q.push_back(n);
      for (int k = 0; k < n; k++) exp_q.push_back(exp_pixel(c, col, pix, k));
      i_vps_core_model.hand(col, pix, f * $urandom_range(3), ok);
      if (!ok) begin
        errors++;
        results();
      end
    end
    repeat (8 * fe + 8) @(negedge sys_clk);
  endtask

  // ****
  // watcher: one note per pixel after each release
  // ****
  initial begin
    int n, pe;
    forever begin
      @(posedge sys_clk);
      #1;
      if (handoff_release === 1'b1) begin
        if (len_q.size() == 0) begin
          compare_bit(1'b1, 1'b0);
        end else begin
          n = len_q.pop_front();
          pe = (pixel_period_count == 8'h00) ? 256 : int'(pixel_period_count);
          @(posedge sys_clk);
          #1;
          compare_bit(handoff_release, 1'b0);
          // sample four cycles into each pixel so a one cycle skew cannot matter
          repeat (4) @(posedge sys_clk);
          #1;
          for (int k = 0; k < n; k++) begin
            compare_pins(pin_out, pin_oe, exp_q.pop_front());
            if (k < n - 1) begin
              repeat (8 * pe) @(posedge sys_clk);
              #1;
            end
          end
        end
      end
    end
  end

  // ****
  // main sequence
  // ****
  initial begin
    vps_exp_t z;
    void'($urandom(32'hcdb359b9));
    z = '{32'h0, 32'h0, 32'h0};
    rst_n = 1'b0;
    broadcast_synth_clock = 1'b1; // held high so the carrier gate is seen open
    tab[0] = '{2'h1, 1'b1, 3'h0, 8'hFF, 8'h01, 12'h010, 1'b0};
    tab[1] = '{2'h1, 1'b0, 3'h3, 8'hA5, 8'h01, 12'h024, 1'b0};
    tab[2] = '{2'h1, 1'b1, 3'h1, 8'h3C, 8'h02, 12'h028, 1'b0};
    tab[3] = '{2'h0, 1'b1, 3'h2, 8'hFF, 8'h01, 12'h008, 1'b0};
    tab[4] = '{2'h1, 1'b0, 3'h5, 8'hFF, 8'h01, 12'h008, 1'b0};
    tab[5] = '{2'h2, 1'b1, 3'h2, 8'hFF, 8'h01, 12'h010, 1'b1};
    tab[6] = '{2'h3, 1'b1, 3'h0, 8'h0F, 8'h01, 12'h010, 1'b1};
    tab[7] = '{2'h2, 1'b0, 3'h1, 8'hF0, 8'h01, 12'h020, 1'b0};
    tab[8] = '{2'h3, 1'b1, 3'h3, 8'hF0, 8'h01, 12'h010, 1'b1};
    tab[9] = '{2'h1, 1'b0, 3'h1, 8'hFF, 8'h00, 12'h200, 1'b0};
    {video_output_kind, color_depth_select, output_pin_group, output_pin_mask} = '0;
    {pixel_period_count, frame_period_count, broadcast_synth_run} = '0;
    repeat (10) @(negedge sys_clk);
    compare_pins(pin_out, pin_oe, z);
    rst_n = 1'b1;
    foreach (tab[i]) run_cfg(tab[i]);
    results();
  end
endmodule // vps_top_tb_top
`default_nettype wire
